// ### logic/pin_sync.sv
// Two-flop synchroniser for a group of inputs from outside the hclk domain.
// Assumes each bit is a level; no bit may be read from the first stage.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

// ### logic/scan_tap.sv
// Boundary-scan test access port with instruction decode, serial registers
// and the read-bus tristate cell; software status over AHB-Lite.
// Assumes the test clock is far slower than hclk (at least 4 hclk per phase).
//
// The AHB-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module scan_tap #(
    parameter int PIN_COUNT = tap_pkg::PIN_COUNT_DEFAULT,
    // Identification fields; values are arbitrary
    parameter logic [2:0] REVISION = 3'h0,
    parameter logic [16:0] PART_TYPE = 17'h0_0123,
    parameter logic [10:0] MAKER_CODE = 11'h055
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Test port pins
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe,
    // Memory pin ring
    input wire logic [PIN_COUNT-1:0] ring_in,
    output logic [PIN_COUNT-1:0] ring_drive,
    output logic extest_active,
    output logic read_bus_oe
);

    localparam int BSR_LEN = PIN_COUNT + 1;
    localparam logic [2:0] TMS_ONES_MAX = 3'(tap_pkg::TMS_RESET_EDGES);

    generate
        if (PIN_COUNT < 1 || PIN_COUNT > 4096) begin : g_bad_count
            $error("PIN_COUNT out of range");
        end
    endgenerate

    function automatic tap_pkg::tap_state_type tap_next(
        input tap_pkg::tap_state_type s, input logic m);
        tap_pkg::tap_state_type n;
        n = s;
        unique case (s)
            tap_pkg::TLR: n = m ? tap_pkg::TLR : tap_pkg::RTI;
            tap_pkg::RTI: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_DR: n = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
            tap_pkg::CAP_DR: n = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::SH_DR: n = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
            tap_pkg::EX1_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
            tap_pkg::PAU_DR: n = m ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
            tap_pkg::EX2_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
            tap_pkg::UPD_DR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
            tap_pkg::SEL_IR: n = m ? tap_pkg::TLR : tap_pkg::CAP_IR;
            tap_pkg::CAP_IR: n = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::SH_IR: n = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
            tap_pkg::EX1_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
            tap_pkg::PAU_IR: n = m ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
            tap_pkg::EX2_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
            tap_pkg::UPD_IR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
        endcase
        return n;
    endfunction

    // Pin synchronisers: test clock sampled and its edges found in hclk
    logic [2:0] tap_pins_s;
    logic [PIN_COUNT-1:0] ring_s;
    logic tck_prev_q;

    pin_sync #(.WIDTH(3)) u_tap_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in({tck, tms, tdi}),
        .sync_out(tap_pins_s)
    );

    // Ring sync trades two cycles of lag for a clean capture
    pin_sync #(.WIDTH(PIN_COUNT)) u_ring_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(ring_in),
        .sync_out(ring_s)
    );

    wire tck_s = tap_pins_s[2];
    wire tms_s = tap_pins_s[1];
    wire tdi_s = tap_pins_s[0];
    wire tck_rise = tck_s & ~tck_prev_q;
    wire tck_fall = ~tck_s & tck_prev_q;

    // Port state
    tap_pkg::tap_state_type state_q;
    tap_pkg::instr_type ir_q;
    logic [tap_pkg::IR_LEN-1:0] ir_sh_q;
    logic [tap_pkg::ID_LEN-1:0] id_sh_q;
    logic [BSR_LEN-1:0] bsr_sh_q;
    logic [BSR_LEN-1:0] pre_q;
    logic byp_q;
    logic soft_reset_q;
    logic [2:0] tms_ones_q;

    wire [tap_pkg::ID_LEN-1:0] id_word = {REVISION, PART_TYPE, MAKER_CODE, 1'b1};
    wire in_tlr = (state_q == tap_pkg::TLR);
    wire sel_bsr = (ir_q == tap_pkg::I_EXTEST) || (ir_q == tap_pkg::I_SAMPLE_Z)
        || (ir_q == tap_pkg::I_PRELOAD);
    wire sel_id = (ir_q == tap_pkg::I_IDCODE);
    // Reserved codes fall back to bypass so the chain stays one bit long
    wire sel_byp = !sel_bsr && !sel_id;
    wire pre_upd = (ir_q == tap_pkg::I_EXTEST) || (ir_q == tap_pkg::I_PRELOAD);
    wire do_cap_dr = tck_rise && (state_q == tap_pkg::CAP_DR);
    wire do_sh_dr = tck_rise && (state_q == tap_pkg::SH_DR);
    wire do_upd_dr = tck_rise && (state_q == tap_pkg::UPD_DR);
    wire dr_lsb = sel_bsr ? bsr_sh_q[0] : (sel_id ? id_sh_q[0] : byp_q);
    wire shifting = (state_q == tap_pkg::SH_DR) || (state_q == tap_pkg::SH_IR);
    wire tdo_d = (state_q == tap_pkg::SH_IR) ? ir_sh_q[0] : dr_lsb;
    wire oe_d = (ir_q == tap_pkg::I_SAMPLE_Z) ? 1'b0
        : (ir_q == tap_pkg::I_EXTEST) ? pre_q[PIN_COUNT] : 1'b1;

    // Controller state; a software reset wins over the test clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tck_prev_q <= 1'b0;
            state_q <= tap_pkg::TLR;
            tms_ones_q <= 3'h0;
        end else begin
            tck_prev_q <= tck_s;
            if (soft_reset_q) begin
                state_q <= tap_pkg::TLR;
            end else if (tck_rise) begin
                state_q <= tap_next(state_q, tms_s);
            end
            if (tck_rise) begin
                tms_ones_q <= !tms_s ? 3'h0
                    : (tms_ones_q == TMS_ONES_MAX ? TMS_ONES_MAX : tms_ones_q + 3'h1);
            end
        end
    end

    // Instruction register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ir_q <= tap_pkg::IR_RESET;
            ir_sh_q <= '0;
        end else if (in_tlr) begin
            ir_q <= tap_pkg::IR_RESET;
        end else if (tck_rise) begin
            unique case (state_q)
                tap_pkg::CAP_IR: ir_sh_q <= {1'b0, tap_pkg::IR_CAPTURE};
                tap_pkg::SH_IR: ir_sh_q <= {tdi_s, ir_sh_q[2:1]};
                tap_pkg::UPD_IR: ir_q <= tap_pkg::instr_type'(ir_sh_q);
                default: ;
            endcase
        end
    end

    // Data registers; capture and shift are independent of memory traffic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            id_sh_q <= '0;
            bsr_sh_q <= '0;
            byp_q <= 1'b0;
        end else if (do_cap_dr) begin
            byp_q <= 1'b0;
            if (sel_id) begin
                id_sh_q <= id_word;
            end
            if (sel_bsr) begin
                bsr_sh_q <= {pre_q[PIN_COUNT], ring_s};
            end
        end else if (do_sh_dr) begin
            if (sel_byp) begin
                byp_q <= tdi_s;
            end
            if (sel_id) begin
                id_sh_q <= {tdi_s, id_sh_q[tap_pkg::ID_LEN-1:1]};
            end
            if (sel_bsr) begin
                bsr_sh_q <= {tdi_s, bsr_sh_q[BSR_LEN-1:1]};
            end
        end
    end

    // Preload latch, cell PIN_COUNT is the read-bus tristate control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pre_q <= {tap_pkg::TRISTATE_RESET, {PIN_COUNT{1'b0}}};
        end else if (in_tlr) begin
            pre_q[PIN_COUNT] <= tap_pkg::TRISTATE_RESET;
        end else if (do_upd_dr && pre_upd) begin
            pre_q <= bsr_sh_q;
        end
    end

    // Ring outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ring_drive <= '0;
            extest_active <= 1'b0;
            read_bus_oe <= 1'b1;
        end else begin
            ring_drive <= pre_q[PIN_COUNT-1:0];
            extest_active <= (ir_q == tap_pkg::I_EXTEST);
            read_bus_oe <= oe_d;
        end
    end

    // Serial output moves only on the falling test clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= tdo_d;
            tdo_oe <= shifting;
        end
    end

    // AHB-Lite slave, zero wait states, always OKAY
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    wire addr_ok = hsel && htrans[1] && hready;
    wire [31:0] status_word = {21'h0, (ir_q == tap_pkg::I_EXTEST), read_bus_oe,
        pre_q[PIN_COUNT], 1'b0, ir_q, state_q};
    wire [31:0] rd_mux = (haddr[7:0] == tap_pkg::STATUS_OFFSET) ? status_word
        : (haddr[7:0] == tap_pkg::IDREAD_OFFSET) ? id_word : 32'h0000_0000;
    wire soft_reset_d = wr_pend_q && (wr_addr_q == tap_pkg::CTRL_OFFSET)
        && hwdata[tap_pkg::CTRL_SOFT_RESET_BIT];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
            soft_reset_q <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok && hwrite;
            soft_reset_q <= soft_reset_d;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
            if (addr_ok && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    // Checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_tlr_loads_id: assert property (in_tlr |=> ir_q == tap_pkg::I_IDCODE)
        else $error("instruction not identification after reset state");
    chk_capture_ir_01: assert property (tck_rise && state_q == tap_pkg::CAP_IR && !soft_reset_q
        |=> ir_sh_q[1:0] == 2'b01)
        else $error("capture-ir pattern wrong");
    chk_id_capture: assert property (do_cap_dr && sel_id
        |=> id_sh_q == {REVISION, PART_TYPE, MAKER_CODE, 1'b1})
        else $error("identification word not captured");
    chk_samplez_float: assert property (ir_q == tap_pkg::I_SAMPLE_Z [*2]
        |-> !read_bus_oe)
        else $error("read bus driven under outputs-off sampling");
    chk_extest_cell: assert property (ir_q == tap_pkg::I_EXTEST
        |=> read_bus_oe == $past(pre_q[PIN_COUNT]))
        else $error("tristate cell not governing read bus");
    chk_tlr_preset: assert property (in_tlr |=> pre_q[PIN_COUNT])
        else $error("tristate latch not preset high");
    chk_bypass_zero: assert property (do_cap_dr |=> !byp_q)
        else $error("bypass not cleared at capture");
    chk_tdo_on_fall: assert property (!tck_fall |=> $stable(tdo))
        else $error("serial output changed off falling edge");
    chk_bypass_path: assert property (tck_fall && state_q == tap_pkg::SH_DR && sel_byp
        |=> tdo == $past(byp_q))
        else $error("bypass bit not on serial output");
    chk_preload_latch: assert property (do_upd_dr && pre_upd && !in_tlr
        |=> pre_q == $past(bsr_sh_q))
        else $error("preload latch not updated");
    chk_sample_ring: assert property (do_cap_dr && ir_q == tap_pkg::I_PRELOAD
        |=> bsr_sh_q[PIN_COUNT-1:0] == $past(ring_s))
        else $error("ring not sampled at capture");
    chk_five_ones: assert property (tms_ones_q == TMS_ONES_MAX |-> in_tlr)
        else $error("five high mode-select edges did not reset");

    cov_extest_float: cover property (ir_q == tap_pkg::I_EXTEST && !read_bus_oe);
    cov_id_shift: cover property (do_sh_dr && sel_id);
    cov_preload_update: cover property (do_upd_dr && ir_q == tap_pkg::I_PRELOAD);

endmodule

// ### logic/tap_pkg.sv
// Constants, state and instruction codes of the boundary-scan test port.
// Assumes nothing beyond a SystemVerilog compiler.
package tap_pkg;

    typedef enum logic [3:0] {
        TLR = 4'b0000,
        RTI = 4'b0001,
        SEL_DR = 4'b0010,
        CAP_DR = 4'b0011,
        SH_DR = 4'b0100,
        EX1_DR = 4'b0101,
        PAU_DR = 4'b0110,
        EX2_DR = 4'b0111,
        UPD_DR = 4'b1000,
        SEL_IR = 4'b1001,
        CAP_IR = 4'b1010,
        SH_IR = 4'b1011,
        EX1_IR = 4'b1100,
        PAU_IR = 4'b1101,
        EX2_IR = 4'b1110,
        UPD_IR = 4'b1111
    } tap_state_type;

    typedef enum logic [2:0] {
        I_EXTEST = 3'b000,
        I_IDCODE = 3'b001,
        I_SAMPLE_Z = 3'b010,
        I_RSVD3 = 3'b011,
        I_PRELOAD = 3'b100,
        I_RSVD5 = 3'b101,
        I_RSVD6 = 3'b110,
        I_BYPASS = 3'b111
    } instr_type;

    // Serial register lengths, capture pattern and reset values
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int PIN_COUNT_DEFAULT = 108;
    localparam logic [1:0] IR_CAPTURE = 2'h1;
    localparam instr_type IR_RESET = I_IDCODE;
    localparam logic TRISTATE_RESET = 1'b1;
    localparam int TMS_RESET_EDGES = 5;

    // Register map, byte addresses
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] IDREAD_OFFSET = 8'h08;
    localparam int CTRL_SOFT_RESET_BIT = 0;
    localparam int STATUS_IR_POS = 4;
    localparam int STATUS_TRI_POS = 8;
    localparam int STATUS_OE_POS = 9;
    localparam int STATUS_EXT_POS = 10;

endpackage

// ### testbench/boundary_scan_tap_instructions_tb_top.sv
// Self-checking bench for the scan port: serial traffic through the
// controller model and status reads over AHB-Lite. Assumes a 20 MHz hclk.
`timescale 1ns/1ps
module boundary_scan_tap_instructions_tb_top;
    localparam int PINS = 108;
    // Identification values are arbitrary
    localparam logic [2:0] REV = 3'h5;
    localparam logic [16:0] PART = 17'h0_A5C3;
    localparam logic [10:0] MAKER = 11'h3A6;
    localparam int LIMIT = 60000;

    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic [PINS-1:0] ring_in = '0;
    logic [PINS-1:0] ring_drive;
    logic extest_active;
    logic read_bus_oe;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [31:0] seed = 32'h0000_0044;
    logic [127:0] din;
    logic [127:0] dout;
    logic [127:0] cap;
    logic [31:0] rd;

    always #25 hclk = ~hclk;

    scan_tap #(.PIN_COUNT(PINS), .REVISION(REV), .PART_TYPE(PART), .MAKER_CODE(MAKER)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_drive(ring_drive),
        .extest_active(extest_active), .read_bus_oe(read_bus_oe)
    );

    jtag_ctl_model link (.hclk(hclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] id_word();
        return {REV, PART, MAKER, 1'b1};
    endfunction

    task automatic results();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask

    task automatic status(input logic [2:0] ir, input logic tri_l, input logic oe,
                          input logic ext);
        ahb(1'b0, 32'(tap_pkg::STATUS_OFFSET), 32'h0000_0000, rd);
        check("status", {rd[tap_pkg::STATUS_EXT_POS], rd[tap_pkg::STATUS_OE_POS],
              rd[tap_pkg::STATUS_TRI_POS], rd[tap_pkg::STATUS_IR_POS +: 3]},
              {ext, oe, tri_l, ir});
        check("hresp", hresp, 1'b0);
    endtask

    // Shifts eight bits past the register so its length shows at the output
    task automatic dr_check(input string nm, input int len, input logic [127:0] capv,
                            input logic t);
        logic [127:0] mask;
        mask = (128'h1 << (len + 8)) - 128'h1;
        din = {rnd(), rnd(), rnd(), rnd()};
        din[len + 7] = t;
        link.scan_dr(len + 8, din, dout);
        check(nm, dout & mask, ((din << len) | (capv & ((128'h1 << len) - 1))) & mask);
        check("tdo_oe_shift", link.oe_count, len + 8);
        check("tdo_oe_idle", tdo_oe, 1'b0);
    endtask

    always @(posedge hclk) begin
        cyc = cyc + 1;
        if (cyc == LIMIT) begin
            num_errors++;
            results();
        end
    end

    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check("oe_reset", read_bus_oe, 1'b1);
        status(3'h1, 1'b1, 1'b1, 1'b0);
        ahb(1'b0, 32'(tap_pkg::IDREAD_OFFSET), 32'h0000_0000, rd);
        check("id_reg", rd, id_word());
        ahb(1'b0, 32'h0000_000C, 32'h0000_0000, rd);
        check("unmapped", rd, 32'h0000_0000);
        link.reset_tap();
        dr_check("idcode", 32, id_word(), 1'b1);
        link.scan_ir(tap_pkg::I_BYPASS, cap);
        check("ir_capture", cap[1:0], 2'h1);
        dr_check("bypass", 1, 128'h0, 1'b0);
        check("bypass_oe", {extest_active, read_bus_oe}, 2'h1);
        // Ring changes only between frames
        for (int k = 0; k < 3; k++) begin
            din = {rnd(), rnd(), rnd(), rnd()};
            ring_in <= din[PINS-1:0];
            link.scan_ir(tap_pkg::I_PRELOAD, cap);
            dr_check("sample", 109, {19'h0, (k == 0) ? 1'b1 : 1'b0, ring_in}, 1'b0);
            check("preload", ring_drive, din[8 +: PINS]);
            check("preload_oe", {extest_active, read_bus_oe}, 2'h1);
        end
        link.scan_ir(tap_pkg::I_EXTEST, cap);
        check("extest", {extest_active, read_bus_oe}, 2'h2);
        check("extest_drive", ring_drive, din[8 +: PINS]);
        dr_check("extest_shift", 109, {20'h0, ring_in}, 1'b1);
        check("tri_high", read_bus_oe, 1'b1);
        check("extest_drive2", ring_drive, din[8 +: PINS]);
        link.scan_ir(tap_pkg::I_SAMPLE_Z, cap);
        check("sample_z", {extest_active, read_bus_oe}, 2'h0);
        dr_check("sample_z_shift", 109, {19'h0, 1'b1, ring_in}, 1'b0);
        check("sample_z_oe", read_bus_oe, 1'b0);
        link.scan_ir(tap_pkg::I_IDCODE, cap);
        check("idcode_oe", read_bus_oe, 1'b1);
        link.scan_ir(tap_pkg::I_PRELOAD, cap);
        dr_check("tri_low", 109, {19'h0, 1'b1, ring_in}, 1'b0);
        status(3'h4, 1'b0, 1'b1, 1'b0);
        link.reset_tap();
        status(3'h1, 1'b1, 1'b1, 1'b0);
        link.scan_ir(tap_pkg::I_BYPASS, cap);
        ahb(1'b1, 32'(tap_pkg::CTRL_OFFSET), 32'h0000_0001, rd);
        repeat (2) @(posedge hclk);
        ahb(1'b0, 32'(tap_pkg::STATUS_OFFSET), 32'h0000_0000, rd);
        check("soft_reset", rd[6:0], 7'h10);
        link.walk(8'h00, 1);
        link.park();
        dr_check("idcode_again", 32, id_word(), 1'b0);
        results();
    end
endmodule

// ### testbench/jtag_ctl_model.sv
// Board-level test controller model: drives the test clock, mode select and
// serial input, and collects the serial output. Assumes a 50 ns hclk.
`timescale 1ns/1ps
module jtag_ctl_model (
    // Clock
    input wire logic hclk,
    // Test port
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe
);
    // Shift ticks of the last frame that saw the serial output enabled
    int oe_count = 0;

    // Pulled-up lines idle high, clock parked low between frames
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 400 ns test clock period; inputs change with the fall
    task automatic tick(input logic m, input logic d, output logic q);
        @(posedge hclk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge hclk);
        tck <= 1'b1;
        repeat (3) @(posedge hclk);
        q = tdo;
    endtask

    task automatic park();
        @(posedge hclk);
        tck <= 1'b0;
        tms <= 1'b1;
        tdi <= 1'b1;
        // Registered port outputs lag the last rise; let them settle
        repeat (4) @(posedge hclk);
    endtask

    // Mode select sequence, first bit first
    task automatic walk(input logic [7:0] ms, input int n);
        logic q;
        for (int i = 0; i < n; i++) begin
            tick(ms[i], 1'b1, q);
        end
    endtask

    task automatic shift(input int n, input logic [127:0] din, output logic [127:0] dout);
        dout = '0;
        oe_count = 0;
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], dout[i]);
            if (tdo_oe === 1'b1) begin
                oe_count++;
            end
        end
    endtask

    task automatic reset_tap();
        walk(8'h1F, 5);
        walk(8'h00, 1);
        park();
    endtask

    // Only implemented codes are ever handed in here
    task automatic scan_ir(input logic [2:0] code, output logic [127:0] cap);
        walk(8'h03, 4);
        shift(3, {125'h0, code}, cap);
        walk(8'h01, 2);
        park();
    endtask

    task automatic scan_dr(input int n, input logic [127:0] din, output logic [127:0] dout);
        walk(8'h01, 3);
        shift(n, din, dout);
        walk(8'h01, 2);
        park();
    endtask
endmodule
